// ===== verilog/ascu_top.sv
// Serial transceiver core: format and control registers, rate generator, transmitter, receiver
`timescale 1ns/100ps
module ascu_top #(
    parameter int CLK_HZ     = ascu_pkg::CLK_HZ,
    parameter int FIFO_DEPTH = ascu_pkg::FIFO_DEPTH
) (
    input  wire logic                CLK_SYS,
    input  wire logic                RESET_N,
    input  wire ascu_pkg::ascu_bus_t BUS_REQ,
    output logic [7:0]               BUS_DOUT,
    output logic                     BUS_DOE_N,
    input  wire logic                RXD,
    output logic                     TXD,
    input  wire logic                DCD_N,
    input  wire logic                DSR_N,
    output logic                     RTS_N,
    output logic                     DTR_N
);
    if (CLK_HZ / (ascu_pkg::OVERSAMPLE * 19200) < 2) begin : g_clk_chk
        $error("ascu_top: CLK_HZ too low for the fastest bit rate");
    end

    typedef struct packed {
        logic              ptr;
        logic [7:0]        fmt1;
        logic [7:0]        fmt2;
        logic [7:0]        ctrl;
        logic [7:0]        dout;
        logic              doe_n;
        logic              rts_n;
        logic              dtr_n;
        logic              txd;
        logic [2:0]        s1;
        logic [2:0]        s2;
        logic [2:0]        s3;
        logic [2:0]        pins;
        logic              modem_chg;
        logic [16:0]       baud_cnt;
        logic              tick;
        ascu_pkg::ascu_tx_t tx_st;
        logic [7:0]        tx_sh;
        logic              tx_par;
        logic [5:0]        tx_tick;
        logic [3:0]        tx_bit;
        ascu_pkg::ascu_rx_t rx_st;
        logic [7:0]        rx_sh;
        logic [3:0]        rx_tick;
        logic [3:0]        rx_bit;
        logic              rx_perr;
        logic [7:0]        rx_data;
        logic              rx_ready;
        logic              pe;
        logic              ovr;
        logic              fe;
    } ascu_state_t;

    ascu_state_t st;
    ascu_state_t next_st;
    logic        fifo_free;
    logic        fifo_valid;
    logic        fifo_pop;
    logic [7:0]  fifo_data;
    logic        wr_data;
    logic        rx_done;
    logic [3:0]  last_bit;
    logic [5:0]  stop_end;
    logic [7:0]  rx_aligned;

    // Parity over the active character bits; odd unless even is asked for
    function automatic logic par_bit(input logic [7:0] d, input logic [1:0] len, input logic even);
        logic [7:0] m;
        m = 8'hFF >> (3'(2'h3 - len));
        return (^(d & m)) ^ ~even;
    endfunction

    assign wr_data    = BUS_REQ.sel && BUS_REQ.wr && BUS_REQ.addr == ascu_pkg::ADDR_DATA;
    assign last_bit   = 4'(st.fmt1[ascu_pkg::FMT1_LEN +: 2]) + 4'h4;
    assign rx_aligned = st.rx_sh >> (3'(2'h3 - st.fmt1[ascu_pkg::FMT1_LEN +: 2]));
    assign fifo_pop   = st.tick && st.tx_st == ascu_pkg::TX_IDLE && st.ctrl[ascu_pkg::CTRL_TX_EN]
                        && !st.ctrl[ascu_pkg::CTRL_BREAK];

    always_comb begin
        unique case (st.fmt1[ascu_pkg::FMT1_STOP +: 2])
            2'b10:   stop_end = ascu_pkg::STOP_ONEHALF;
            2'b11:   stop_end = ascu_pkg::STOP_TWO;
            default: stop_end = ascu_pkg::STOP_ONE;
        endcase
    end

    // Writes wait here while the shifter is busy; a stalled or disabled transmitter fills it
    ascu_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_tx_fifo (
        .clk       (CLK_SYS),
        .reset_n   (RESET_N),
        .in_valid  (wr_data),
        .in_ready  (fifo_free),
        .in_data   (BUS_REQ.wdata),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_data)
    );

    always_comb begin
        next_st = st;
        rx_done = 1'b0;
        // Pins: first stage feeds only the second; a change counts once stages 2 and 3 agree
        next_st.s1   = {DSR_N, DCD_N, RXD};
        next_st.s2   = st.s1;
        next_st.s3   = st.s2;
        next_st.pins = (st.s2 & st.s3) | (st.pins & (st.s2 | st.s3));
        next_st.doe_n = 1'b1;
        // 16x tick from the selected rate
        next_st.tick     = (st.baud_cnt == '0);
        next_st.baud_cnt = next_st.tick ? ascu_pkg::ascu_divisor(st.fmt2[3:0], CLK_HZ)
                                        : st.baud_cnt - 17'h1;
        // Register port writes
        if (BUS_REQ.sel && BUS_REQ.wr && BUS_REQ.addr == ascu_pkg::ADDR_FORMAT) begin
            if (!st.ptr) begin
                next_st.fmt1 = BUS_REQ.wdata;
            end else begin
                next_st.fmt2 = BUS_REQ.wdata;
            end
            next_st.ptr = ~st.ptr;
        end
        if (BUS_REQ.sel && BUS_REQ.wr && BUS_REQ.addr == ascu_pkg::ADDR_CONTROL) begin
            next_st.ctrl = BUS_REQ.wdata;
            if (BUS_REQ.wdata[ascu_pkg::CTRL_ERR_CLR]) begin
                next_st.pe  = 1'b0;
                next_st.ovr = 1'b0;
                next_st.fe  = 1'b0;
            end
        end
        // Register port reads, with their side effects
        if (BUS_REQ.sel && BUS_REQ.rd) begin
            next_st.doe_n = 1'b0;
            unique case (BUS_REQ.addr)
                ascu_pkg::ADDR_DATA: begin
                    next_st.dout     = st.rx_data;
                    next_st.rx_ready = 1'b0;
                end
                ascu_pkg::ADDR_STATUS: begin
                    next_st.dout = {~st.pins[2], ~st.pins[1], st.fe, st.ovr, st.pe,
                                    st.modem_chg || (st.tx_st == ascu_pkg::TX_IDLE && !fifo_valid),
                                    st.rx_ready, fifo_free};
                    next_st.modem_chg = 1'b0;
                end
                ascu_pkg::ADDR_FORMAT: begin
                    next_st.dout = st.ptr ? st.fmt2 : st.fmt1;
                end
                ascu_pkg::ADDR_CONTROL: begin
                    next_st.dout = st.ctrl;
                end
            endcase
        end
        // Modem line change is set after the read clear so a coincident change is kept
        if (next_st.pins[2:1] != st.pins[2:1]) begin
            next_st.modem_chg = 1'b1;
        end
        // Transmitter
        if (st.tick && st.tx_st != ascu_pkg::TX_IDLE) begin
            next_st.tx_tick = st.tx_tick + 6'h1;
        end
        unique case (st.tx_st)
            ascu_pkg::TX_IDLE: begin
                if (fifo_pop && fifo_valid) begin
                    next_st.tx_sh   = fifo_data;
                    next_st.tx_par  = par_bit(fifo_data, st.fmt1[ascu_pkg::FMT1_LEN +: 2],
                                              st.fmt1[ascu_pkg::FMT1_PAR_EVN]);
                    next_st.tx_tick = '0;
                    next_st.tx_bit  = '0;
                    next_st.tx_st   = ascu_pkg::TX_START;
                end
            end
            ascu_pkg::TX_START: begin
                if (st.tick && st.tx_tick[3:0] == ascu_pkg::LAST_TICK) begin
                    next_st.tx_tick = '0;
                    next_st.tx_st   = ascu_pkg::TX_DATA;
                end
            end
            ascu_pkg::TX_DATA: begin
                if (st.tick && st.tx_tick[3:0] == ascu_pkg::LAST_TICK) begin
                    next_st.tx_tick = '0;
                    next_st.tx_sh   = st.tx_sh >> 1;
                    next_st.tx_bit  = st.tx_bit + 4'h1;
                    if (st.tx_bit == last_bit) begin
                        next_st.tx_st = st.fmt1[ascu_pkg::FMT1_PAR_EN] ? ascu_pkg::TX_PAR
                                                                       : ascu_pkg::TX_STOP;
                    end
                end
            end
            ascu_pkg::TX_PAR: begin
                if (st.tick && st.tx_tick[3:0] == ascu_pkg::LAST_TICK) begin
                    next_st.tx_tick = '0;
                    next_st.tx_st   = ascu_pkg::TX_STOP;
                end
            end
            ascu_pkg::TX_STOP: begin
                if (st.tick && st.tx_tick == stop_end) begin
                    next_st.tx_st = ascu_pkg::TX_IDLE;
                end
            end
            default: begin
                next_st.tx_st = ascu_pkg::TX_IDLE;
            end
        endcase
        unique case (next_st.tx_st)
            ascu_pkg::TX_START: next_st.txd = 1'b0;
            ascu_pkg::TX_DATA:  next_st.txd = next_st.tx_sh[0];
            ascu_pkg::TX_PAR:   next_st.txd = next_st.tx_par;
            default:            next_st.txd = 1'b1;
        endcase
        // Break wins over any character, even one in flight
        if (next_st.ctrl[ascu_pkg::CTRL_BREAK]) begin
            next_st.txd = 1'b0;
        end
        // Receiver, sampling mid-bit on the 16x tick
        if (st.tick && st.rx_st != ascu_pkg::RX_IDLE) begin
            next_st.rx_tick = st.rx_tick + 4'h1;
        end
        unique case (st.rx_st)
            ascu_pkg::RX_IDLE: begin
                if (st.tick && !st.pins[0]) begin
                    next_st.rx_tick = '0;
                    next_st.rx_st   = ascu_pkg::RX_START;
                end
            end
            ascu_pkg::RX_START: begin
                if (st.tick && st.rx_tick == ascu_pkg::MID_TICK) begin
                    next_st.rx_tick = '0;
                    next_st.rx_bit  = '0;
                    next_st.rx_perr = 1'b0;
                    next_st.rx_st   = st.pins[0] ? ascu_pkg::RX_IDLE : ascu_pkg::RX_DATA;
                end
            end
            ascu_pkg::RX_DATA: begin
                if (st.tick && st.rx_tick == ascu_pkg::LAST_TICK) begin
                    next_st.rx_sh  = {st.pins[0], st.rx_sh[7:1]};
                    next_st.rx_bit = st.rx_bit + 4'h1;
                    if (st.rx_bit == last_bit) begin
                        next_st.rx_st = st.fmt1[ascu_pkg::FMT1_PAR_EN] ? ascu_pkg::RX_PAR
                                                                       : ascu_pkg::RX_STOP;
                    end
                end
            end
            ascu_pkg::RX_PAR: begin
                if (st.tick && st.rx_tick == ascu_pkg::LAST_TICK) begin
                    next_st.rx_perr = st.pins[0] != par_bit(rx_aligned, st.fmt1[ascu_pkg::FMT1_LEN +: 2],
                                                            st.fmt1[ascu_pkg::FMT1_PAR_EVN]);
                    next_st.rx_st   = ascu_pkg::RX_STOP;
                end
            end
            ascu_pkg::RX_STOP: begin
                if (st.tick && st.rx_tick == ascu_pkg::LAST_TICK) begin
                    rx_done          = 1'b1;
                    next_st.rx_data  = rx_aligned;
                    // Built on the cleared value: a coincident clear drops old flags, a new error still sets
                    next_st.fe       = next_st.fe || !st.pins[0];
                    next_st.pe       = next_st.pe || st.rx_perr;
                    next_st.ovr      = next_st.ovr || st.rx_ready;
                    next_st.rx_ready = 1'b1;
                    next_st.rx_st    = ascu_pkg::RX_IDLE;
                end
            end
            default: begin
                next_st.rx_st = ascu_pkg::RX_IDLE;
            end
        endcase
        if (!next_st.ctrl[ascu_pkg::CTRL_RX_EN]) begin
            next_st.rx_st = ascu_pkg::RX_IDLE;
        end
        next_st.rts_n = ~next_st.ctrl[ascu_pkg::CTRL_RTS];
        next_st.dtr_n = ~next_st.ctrl[ascu_pkg::CTRL_DTR];
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            st          <= '0;
            st.fmt1     <= ascu_pkg::FMT1_RESET;
            st.fmt2     <= ascu_pkg::FMT2_RESET;
            st.ctrl     <= ascu_pkg::CTRL_RESET;
            st.doe_n    <= 1'b1;
            st.rts_n    <= 1'b1;
            st.dtr_n    <= 1'b1;
            st.txd      <= 1'b1;
            st.s1       <= 3'h7;
            st.s2       <= 3'h7;
            st.s3       <= 3'h7;
            st.pins     <= 3'h7;
        end else begin
            st <= next_st;
        end
    end

    assign BUS_DOUT  = st.dout;
    assign BUS_DOE_N = st.doe_n;
    assign TXD       = st.txd;
    assign RTS_N     = st.rts_n;
    assign DTR_N     = st.dtr_n;

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESET_N);

    sequence fmt_wr_s;
        BUS_REQ.sel && BUS_REQ.wr && BUS_REQ.addr == ascu_pkg::ADDR_FORMAT;
    endsequence
    sequence ctrl_wr_s;
        BUS_REQ.sel && BUS_REQ.wr && BUS_REQ.addr == ascu_pkg::ADDR_CONTROL;
    endsequence
    sequence tx_launch_s;
        st.tx_st == ascu_pkg::TX_IDLE ##1 st.tx_st == ascu_pkg::TX_START;
    endsequence
    sequence rd_take_s;
        BUS_REQ.sel && BUS_REQ.rd;
    endsequence

    first_format_a: assert property ((fmt_wr_s and !st.ptr) |=> st.ptr && st.fmt1 == $past(BUS_REQ.wdata))
        else $error("first format write missed");
    second_format_a: assert property ((fmt_wr_s and st.ptr) |=> !st.ptr && st.fmt2 == $past(BUS_REQ.wdata))
        else $error("second format write or pointer return missed");
    dtr_follow_a: assert property (ctrl_wr_s |=> DTR_N == !$past(BUS_REQ.wdata[1]))
        else $error("terminal ready output wrong");
    rts_follow_a: assert property (ctrl_wr_s |=> RTS_N == !$past(BUS_REQ.wdata[5]))
        else $error("request to send output wrong");
    err_clear_a: assert property ((ctrl_wr_s and BUS_REQ.wdata[4] and !rx_done) |=> !st.pe && !st.ovr && !st.fe)
        else $error("error flags not cleared");
    break_hold_a: assert property (st.ctrl[ascu_pkg::CTRL_BREAK] |-> !TXD)
        else $error("break not held on serial output");
    tx_gate_a: assert property ((st.tx_st == ascu_pkg::TX_IDLE && !st.ctrl[0]) |=> st.tx_st == ascu_pkg::TX_IDLE)
        else $error("transmitter started while disabled");
    rx_gate_a: assert property (!st.ctrl[ascu_pkg::CTRL_RX_EN] |-> st.rx_st == ascu_pkg::RX_IDLE)
        else $error("receiver active while disabled");
    start_bit_a: assert property (tx_launch_s |-> !TXD ##1 (st.tx_st != ascu_pkg::TX_IDLE))
        else $error("start bit not sent");
    rx_flags_a: assert property (rx_done |=> st.rx_ready && (st.ovr || !$past(st.rx_ready)))
        else $error("receive ready or overrun not flagged");
    read_answer_a: assert property (rd_take_s |=> !BUS_DOE_N)
        else $error("read answer not driven");
    read_quiet_a: assert property (!(BUS_REQ.sel && BUS_REQ.rd) |=> BUS_DOE_N)
        else $error("read answer without a read");
    idle_mark_a: assert property ((st.tx_st == ascu_pkg::TX_IDLE && !st.ctrl[ascu_pkg::CTRL_BREAK]) |-> TXD)
        else $error("serial output not at mark while idle");
endmodule

// ===== verilog/ascu_pkg.sv
// Shared constants, carrier types and the behaviour list of the serial transceiver
// Function
// - Two format registers share one port; an internal pointer picks which one a write hits.
// - First format register bits 1:0 are 10; the core runs asynchronously, sampling 16x.
// - First format bits 3:2 give five to eight data bits, both directions.
// - First format bit 4 adds a parity bit after the data bits.
// - First format bit 5 picks even parity when set, odd when clear; ignored otherwise.
// - First format bits 7:6 give one, one and a half or two stop bits.
// - Second format bits 3:0 pick one of sixteen generated bit rates.
// - Line control bit 0 enables the transmitter; when clear no new character starts, one in flight finishes.
// - Terminal-ready output is the inverse of line control bit 1.
// - Line control bit 2 enables the receiver; when clear incoming characters are ignored.
// - Line control bit 3 holds the serial output in break.
// - Writing line control bit 4 as one clears parity, overrun and framing flags.
// - Request-to-send output is the inverse of line control bit 5.
// - Status bit 0 shows transmit space, bit 1 a received character waiting.
// - Status bits 3, 4, 5 flag parity error, overrun and framing error.
// - Start and stop bits are added on send and stripped on receive.
package ascu_pkg;
    localparam int         CLK_HZ       = 100_000_000;
    localparam int         OVERSAMPLE   = 16;
    localparam int         FIFO_DEPTH   = 8;
    localparam logic [3:0] MID_TICK     = 4'h7;
    localparam logic [3:0] LAST_TICK    = 4'hF;
    localparam logic [5:0] STOP_ONE     = 6'h0F;
    localparam logic [5:0] STOP_ONEHALF = 6'h17;
    localparam logic [5:0] STOP_TWO     = 6'h1F;
    localparam logic [1:0] ADDR_DATA    = 2'h0;
    localparam logic [1:0] ADDR_STATUS  = 2'h1;
    localparam logic [1:0] ADDR_FORMAT  = 2'h2;
    localparam logic [1:0] ADDR_CONTROL = 2'h3;
    localparam logic [7:0] FMT1_RESET   = 8'h4E;
    localparam logic [7:0] FMT2_RESET   = 8'h7E;
    localparam logic [7:0] CTRL_RESET   = 8'h00;
    localparam int         FMT1_LEN     = 2;
    localparam int         FMT1_PAR_EN  = 4;
    localparam int         FMT1_PAR_EVN = 5;
    localparam int         FMT1_STOP    = 6;
    localparam int         CTRL_TX_EN   = 0;
    localparam int         CTRL_DTR     = 1;
    localparam int         CTRL_RX_EN   = 2;
    localparam int         CTRL_BREAK   = 3;
    localparam int         CTRL_ERR_CLR = 4;
    localparam int         CTRL_RTS     = 5;
    localparam int         RATE_X10 [16] = '{500, 750, 1100, 1345, 1500, 3000, 6000, 12000,
                                             18000, 20000, 24000, 36000, 48000, 72000, 96000, 192000};

    typedef struct packed {
        logic       sel;
        logic       rd;
        logic       wr;
        logic [1:0] addr;
        logic [7:0] wdata;
    } ascu_bus_t;

    typedef enum logic [2:0] {
        TX_IDLE  = 3'b000,
        TX_START = 3'b001,
        TX_DATA  = 3'b010,
        TX_PAR   = 3'b011,
        TX_STOP  = 3'b100
    } ascu_tx_t;

    typedef enum logic [2:0] {
        RX_IDLE  = 3'b000,
        RX_START = 3'b001,
        RX_DATA  = 3'b010,
        RX_PAR   = 3'b011,
        RX_STOP  = 3'b100
    } ascu_rx_t;

    // Reload value of the 16x divider, i.e. cycles per tick minus one
    function automatic logic [16:0] ascu_divisor(input logic [3:0] code, input int clk_hz);
        int div;
        div = (clk_hz / OVERSAMPLE) * 10 / RATE_X10[code];
        if (div < 1) div = 1;
        return 17'(div - 1);
    endfunction
endpackage

// ===== verilog/ascu_fifo.sv
// Transmit holding FIFO with valid/ready on both sides
`timescale 1ns/100ps
module ascu_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_chk
        $error("ascu_fifo: DEPTH must be a power of two, at least 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               rd;
        logic [AW-1:0]               wr;
        logic [AW:0]                 cnt;
    } ascu_fifo_state_t;

    ascu_fifo_state_t st;
    ascu_fifo_state_t next_st;
    logic             push;
    logic             pop;

    assign in_ready  = (st.cnt != (AW+1)'(DEPTH));
    assign out_valid = (st.cnt != '0);
    assign out_data  = st.mem[st.rd];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wr] = in_data;
            next_st.wr         = st.wr + AW'(1);
        end
        if (pop) begin
            next_st.rd = st.rd + AW'(1);
        end
        next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// ===== verification/ascu_term.sv
// Behavioural serial terminal that sits on the far end of the line
`timescale 1ns/100ps
module ascu_term #(
    parameter int BIT_NS = 1600
) (
    input  wire logic txd,
    output logic      rxd
);
    int         nbits   = 8;
    logic       par_en  = 1'b0;
    int         frames  = 0;
    logic [7:0] got     = 8'h00;
    logic       got_par = 1'b0;
    realtime    t_start = 0;
    realtime    t_gap   = 0;

    initial rxd = 1'b1;

    // Mid-bit sampling from the start edge, data LSB first
    always begin
        @(negedge txd);
        t_gap   = $realtime - t_start;
        t_start = $realtime;
        #(BIT_NS / 2);
        got = 8'h00;
        for (int i = 0; i < nbits; i++) begin
            #(BIT_NS);
            got[i] = txd;
        end
        if (par_en) begin
            #(BIT_NS);
            got_par = txd;
        end
        #(BIT_NS);
        frames++;
    end

    // Frame bits come in ready built, start bit first; line returns to mark afterwards
    task automatic send_raw(input logic [11:0] frame, input int n);
        for (int i = 0; i < n; i++) begin
            rxd = frame[i];
            #(BIT_NS);
        end
        rxd = 1'b1;
    endtask
endmodule

// ===== verification/tb.sv
// Self-checking bench for the serial transceiver with a terminal on the line
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
    localparam logic [7:0] TXF [4] = '{8'h42, 8'h96, 8'hFA, 8'hEE};
    localparam logic [7:0] CTV [4] = '{8'h22, 8'h20, 8'h02, 8'h00};
    logic                clk_sys = 1'b0;
    logic                reset_n = 1'b0;
    ascu_pkg::ascu_bus_t bus_req = '0;
    logic [7:0]          bus_dout;
    logic                bus_doe_n;
    logic                rxd;
    logic                txd;
    logic                rts_n;
    logic                dtr_n;
    logic                dcd_n = 1'b0;
    logic                dsr_n = 1'b1;
    int                  fails = 0;
    int                  num_checks = 0;
    logic [7:0]          rv;

    always #5 clk_sys = ~clk_sys;

    // Lowered clock rate gives ten cycles per 16x tick at the fastest rate code
    ascu_top #(.CLK_HZ(3200000), .FIFO_DEPTH(8)) DUT (.CLK_SYS(clk_sys), .RESET_N(reset_n),
        .BUS_REQ(bus_req), .BUS_DOUT(bus_dout), .BUS_DOE_N(bus_doe_n), .RXD(rxd), .TXD(txd),
        .DCD_N(dcd_n), .DSR_N(dsr_n), .RTS_N(rts_n), .DTR_N(dtr_n));
    ascu_term #(.BIT_NS(1600)) term (.txd(txd), .rxd(rxd));

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk_sys) #1;
        bus_req = '{sel: 1'b1, rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge clk_sys) #1;
        bus_req = '0;
    endtask
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk_sys) #1;
        bus_req = '{sel: 1'b1, rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(posedge clk_sys) #1;
        bus_req = '0;
        d = bus_dout;
        `CHK(bus_doe_n, 1'b0)
    endtask
    task automatic cfg(input logic [7:0] f);
        wr(2'h2, f);
        wr(2'h2, 8'h7F);
    endtask
    task automatic wait_frames(input int n);
        for (int i = 0; i < 20000 && term.frames < n; i++) @(posedge clk_sys);
        `CHK(term.frames >= n, 1'b1)
    endtask
    task automatic rxf(input logic [7:0] d, input logic flip, input logic stp);
        term.send_raw({1'b1, stp, (^d) ^ flip, d, 1'b0}, 11);
        #50;
    endtask

    task automatic t_reset;
        rd(2'h2, rv); `CHK(rv, 8'h4E)
        rd(2'h3, rv); `CHK(rv, 8'h00)
        rd(2'h1, rv); `CHK(rv, 8'h45)
        `CHK({txd, rts_n, dtr_n}, 3'b111)
        wr(2'h2, 8'h4E); rd(2'h2, rv); `CHK(rv, 8'h7E)
        wr(2'h2, 8'h7F); rd(2'h2, rv); `CHK(rv, 8'h4E)
        rd(2'h2, rv); `CHK(rv, 8'h4E)
        $display("done reset and pointer");
    endtask
    task automatic t_control;
        for (int k = 0; k < 4; k++) begin
            wr(2'h3, CTV[k]);
            @(posedge clk_sys) #1;
            `CHK(rts_n, ~CTV[k][5])
            `CHK(dtr_n, ~CTV[k][1])
            rd(2'h3, rv); `CHK(rv, CTV[k])
        end
        dcd_n = 1'b1;
        dsr_n = 1'b0;
        repeat (5) @(posedge clk_sys);
        rd(2'h1, rv); `CHK(rv & 8'hC0, 8'h80)
        $display("done control");
    endtask
    task automatic t_tx;
        logic [7:0] f;
        logic [7:0] md;
        int         nb;
        int         n0;
        int         ex;
        for (int k = 0; k < 4; k++) begin
            f = TXF[k];
            nb = int'(f[3:2]) + 5;
            md = 8'hB5 & (8'hFF >> (8 - nb));
            ex = ((1 + nb + int'(f[4])) * 16 + (f[7:6] == 2'b01 ? 16 : f[7:6] == 2'b10 ? 24 : 32)) * 100;
            term.nbits = nb;
            term.par_en = f[4];
            cfg(f);
            wr(2'h3, 8'h01);
            n0 = term.frames;
            wr(2'h0, 8'h3C);
            wr(2'h0, 8'hB5);
            wait_frames(n0 + 2);
            `CHK(term.got, md)
            if (f[4]) `CHK(term.got_par, (^md) ^ ~f[5])
            `CHK(term.t_gap >= ex && term.t_gap <= ex + 300, 1'b1)
            #6400;
        end
        $display("done transmit formats");
    endtask
    task automatic t_break;
        int n0;
        term.nbits = 8;
        term.par_en = 1'b0;
        cfg(8'h4E);
        wr(2'h3, 8'h09);
        repeat (2) @(posedge clk_sys);
        `CHK(txd, 1'b0)
        wr(2'h0, 8'h5A);
        #32000 `CHK(txd, 1'b0)
        wr(2'h3, 8'h00);
        #19200 n0 = term.frames;
        #19200 `CHK(term.frames, n0)
        `CHK(txd, 1'b1)
        wr(2'h3, 8'h01);
        wait_frames(n0 + 1);
        `CHK(term.got, 8'h5A)
        $display("done break and enable");
    endtask
    task automatic t_rx;
        cfg(8'h7E);
        wr(2'h3, 8'h04);
        rxf(8'hA5, 1'b0, 1'b1); rd(2'h1, rv); `CHK(rv & 8'h3A, 8'h02)
        rd(2'h0, rv); `CHK(rv, 8'hA5)
        rd(2'h1, rv); `CHK(rv & 8'h02, 8'h00)
        rxf(8'h3C, 1'b1, 1'b1); rd(2'h1, rv); `CHK(rv & 8'h38, 8'h08)
        rd(2'h0, rv);
        rxf(8'h11, 1'b0, 1'b1); rxf(8'h22, 1'b0, 1'b1);
        rd(2'h1, rv); `CHK(rv & 8'h38, 8'h18)
        rd(2'h0, rv); `CHK(rv, 8'h22)
        rxf(8'h44, 1'b0, 1'b0); rd(2'h1, rv); `CHK(rv & 8'h38, 8'h38)
        wr(2'h3, 8'h04); rd(2'h1, rv); `CHK(rv & 8'h38, 8'h38)
        wr(2'h3, 8'h14); rd(2'h1, rv); `CHK(rv & 8'h38, 8'h00)
        rd(2'h0, rv);
        wr(2'h3, 8'h00);
        rxf(8'h66, 1'b0, 1'b1); rd(2'h1, rv); `CHK(rv & 8'h02, 8'h00)
        $display("done receive and errors");
    endtask

    task automatic end_sim;
        $display("checks=%0d fails=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Whole sequence needs about 34k cycles; three times that means a hang
    initial begin
        #1000000;
        fails++;
        end_sim();
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        #1 reset_n = 1'b1;
        t_reset();
        t_control();
        t_tx();
        t_break();
        t_rx();
        end_sim();
    end
endmodule
